// ===== core/msd_consts.svh
// constants for the mode status and address decode block
// assumes inclusion by the mode latch, address map and top modules that need offsets
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH

// ************************************************************
// register map (word indices; the apb byte address is four times the index)
// ************************************************************
`define MSD_MODE_IND_OFS    16'hffc5
`define MSD_RAM_CTRL_OFS    16'hffc4
`define MSD_DEC_ADDR_OFS    16'hff00
`define MSD_DEC_RES_OFS     16'hff04
`define MSD_VARIANT_OFS     16'hff08

// ************************************************************
// field positions and fixed values
// ************************************************************
`define MSD_MODE_FIXED      6'b1110_01
`define MSD_ONCHIP_RAM_ENABLE_BIT        0
`define MSD_RAM_CTRL_RST    8'h09

// ************************************************************
// address map boundaries
// ************************************************************
`define MSD_VEC_END         16'h0047
`define MSD_ROM48_END       16'hbfff
`define MSD_ROM32_END       16'h7fff
`define MSD_ROM24_END       16'h5fff
`define MSD_EXP_ROM_GAP     16'hc000
`define MSD_RAM2K_START     16'hf780
`define MSD_RAM1K_START     16'hfb80
`define MSD_RAM_END         16'hff7f
`define MSD_EXT_HOLE_END    16'hff87
`define MSD_REG_START       16'hff88

`endif

// ===== core/msd_pkg.sv
// types shared by the mode status and address decode block
// assumes the constants header sits beside it
package msd_pkg;
  // decoded region, one-hot
  typedef enum logic [5:0] {
    MSD_VEC  = 6'b00_0001,
    MSD_ROM  = 6'b00_0010,
    MSD_RAM  = 6'b00_0100,
    MSD_REG  = 6'b00_1000,
    MSD_EXT  = 6'b01_0000,
    MSD_RSV  = 6'b10_0000
  } msd_region_t;

  // memory size variant
  typedef enum logic [1:0] {
    MSD_V48K = 2'b00,
    MSD_V32K = 2'b01,
    MSD_V24K = 2'b10
  } msd_variant_t;
endpackage

// ===== core/msd_mode_latch.sv
// mode indicator register: latches the mode pins on each read
// assumes the mode pins are synchronous to pclk
`timescale 1ns/1ps
`include "msd_consts.svh"
module msd_mode_latch (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // mode pins and read strobe
  input  wire logic       upper_mode_pin,
  input  wire logic       lower_mode_pin,
  input  wire logic       rd_strobe,
  // register value
  output logic      [7:0] mode_value
);
  logic [1:0] mode_sel_q;
  logic       init_q;

  // latch on read
  // pins also caught once after reset, since the async reset may not take a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel_q <= 2'b00;
      init_q     <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (rd_strobe || !init_q) begin
        mode_sel_q <= {upper_mode_pin, lower_mode_pin};
      end
    end
  end

  assign mode_value = {`MSD_MODE_FIXED, mode_sel_q};
endmodule

// ===== core/msd_addr_map.sv
// combinational map of one cpu address to a region
// assumes mode and ram enable are stable while the address is decoded
`timescale 1ns/1ps
`include "msd_consts.svh"
module msd_addr_map
  import msd_pkg::*;
(
  // inputs
  input  wire logic [15:0]         addr,
  input  wire logic [1:0]          mode,
  input  wire logic                ram_en,
  input  msd_pkg::msd_variant_t    variant,
  // result
  output msd_pkg::msd_region_t     region
);
  // mode codes from the pins: 01 expanded no rom, 10 expanded rom, 11 single
  wire        mode_norom  = (mode == 2'b01);
  wire        single      = (mode == 2'b11);
  wire [15:0] rom_end     = (variant == MSD_V48K) ? `MSD_ROM48_END :
                            (variant == MSD_V32K) ? `MSD_ROM32_END : `MSD_ROM24_END;
  wire [15:0] ram_start   = (variant == MSD_V48K) ? `MSD_RAM2K_START : `MSD_RAM1K_START;
  wire        in_vec      = (addr <= `MSD_VEC_END);
  wire        in_rom      = (addr <= rom_end);
  wire        in_ram      = (addr >= ram_start) && (addr <= `MSD_RAM_END);
  wire        in_rsv_ram  = (addr >= `MSD_RAM2K_START) && (addr < ram_start);
  wire        in_hole     = (addr > `MSD_RAM_END) && (addr <= `MSD_EXT_HOLE_END);
  wire        in_reg      = (addr >= `MSD_REG_START);
  wire        in_rom_gap  = (addr > rom_end) && (addr < `MSD_EXP_ROM_GAP);

  always_comb begin
    region = MSD_EXT;
    if (in_reg) begin
      region = MSD_REG;
    end else if (in_ram) begin
      region = (ram_en || single) ? MSD_RAM : MSD_EXT;
    end else if (in_hole || in_rsv_ram) begin
      region = single ? MSD_RSV : (in_hole ? MSD_EXT : MSD_RSV);
    end else if (mode_norom) begin
      region = in_vec ? MSD_VEC : MSD_EXT;
    end else if (in_vec) begin
      region = MSD_VEC;
    end else if (in_rom) begin
      region = MSD_ROM;
    end else if (in_rom_gap) begin
      region = MSD_RSV;
    end else begin
      region = single ? MSD_RSV : MSD_EXT;
    end
  end
endmodule

// ===== core/msd_top.sv
// mode status and address decode: apb register slave plus cpu address decoder
// assumes an apb master on pclk and a cpu address bus sampled each cycle
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "msd_consts.svh"

// Function
// - bit 1 shows upper mode pin, bit 0 lower mode pin
// - each read of mode register samples both pins and returns them
// - writes to mode-select bits are ignored
// - no-rom expanded: all external except ram, register field, vector table, and f780..fb7f reserved in 1k ram variants
// - rom modes: rom from zero; expanded from rom end+gap goes external
// - ff88..ffff register field always; ff80..ff87 external in expanded modes
// - 1k ram fb80..ff7f, f780..fb7f reserved; 2k ram starts f780
// - expanded modes with ram disabled send ram range external
module msd_top
  import msd_pkg::*;
#(
  parameter msd_variant_t VARIANT = MSD_V48K
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mode pins
  input  wire logic        upper_mode_pin,
  input  wire logic        lower_mode_pin,
  // cpu address decode
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_valid,
  output logic      [5:0]  cpu_region,
  output logic             ext_cycle
);
  import msd_pkg::*;

  // ************************************************************
  // apb decode
  // ************************************************************
  // offsets are word indices: paddr bits 17:2 carry the index, bits 1:0 are ignored
  function automatic logic hit(input logic [17:0] a, input logic [15:0] ofs);
    hit = (a[17:2] == ofs);
  endfunction

  wire acc       = psel && penable;
  wire sel_mode  = hit(paddr, `MSD_MODE_IND_OFS);
  wire sel_ctrl  = hit(paddr, `MSD_RAM_CTRL_OFS);
  wire sel_daddr = hit(paddr, `MSD_DEC_ADDR_OFS);
  wire sel_dres  = hit(paddr, `MSD_DEC_RES_OFS);
  wire sel_var   = hit(paddr, `MSD_VARIANT_OFS);
  wire mapped    = sel_mode || sel_ctrl || sel_daddr || sel_dres || sel_var;

  // each register owns a whole word, so a write to the control byte
  // can never touch the mode byte

  // ************************************************************
  // registers
  // ************************************************************
  logic        ram_en_q;
  logic        ram_en_d;
  logic [15:0] dec_addr_q;
  logic [15:0] dec_addr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pslverr_q;
  logic [5:0]  cpu_region_q;
  logic        ext_cycle_q;
  logic [7:0]  mode_value;
  logic [1:0]  mode_live;
  msd_region_t sw_region;
  msd_region_t cpu_region_w;

  // writes land only at the edge where the master sees pready high
  wire wr_en = acc && pwrite && pready_q;
  wire rd_en = acc && !pwrite && !pready_q;

  wire mode_rd = psel && !penable && !pwrite && sel_mode;

  // mode bits not writable
  // the mode word ignores writes; only the control and probe address words take them
  assign ram_en_d   = (wr_en && sel_ctrl) ? pwdata[`MSD_ONCHIP_RAM_ENABLE_BIT] : ram_en_q;
  assign dec_addr_d = (wr_en && sel_daddr) ? pwdata[15:0] : dec_addr_q;
  assign mode_live  = mode_value[1:0];

  // ************************************************************
  // sub blocks
  // ************************************************************
  // mode latch: strobed in the setup phase so data is ready for access
  msd_mode_latch u_mode (
    .pclk           (pclk),
    .presetn        (presetn),
    .upper_mode_pin (upper_mode_pin),
    .lower_mode_pin (lower_mode_pin),
    .rd_strobe      (mode_rd),
    .mode_value     (mode_value)
  );

  // decoder driven by software probe address
  msd_addr_map u_sw_map (
    .addr    (dec_addr_q),
    .mode    (mode_live),
    .ram_en  (ram_en_q),
    .variant (VARIANT),
    .region  (sw_region)
  );

  // decoder driven by cpu address
  msd_addr_map u_cpu_map (
    .addr    (cpu_addr),
    .mode    (mode_live),
    .ram_en  (ram_en_q),
    .variant (VARIANT),
    .region  (cpu_region_w)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  // fixed bits returned
  // mode bits in low byte
  // control byte: bit 3 reads one, bit 0 is the live ram enable
  assign prdata_d = sel_mode  ? {24'h00_0000, mode_value} :
                    sel_ctrl  ? {24'h00_0000, (`MSD_RAM_CTRL_RST & 8'hfe) | {7'h00, ram_en_q}} :
                    sel_daddr ? {16'h0000, dec_addr_q} :
                    sel_dres  ? {26'h000_0000, sw_region} :
                    sel_var   ? {30'h0000_0000, VARIANT} :
                                32'h0000_0000;

  // ************************************************************
  // apb handshake: one wait state, answer in the second access cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      if (rd_en) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_en_q   <= 1'b1;
      dec_addr_q <= 16'h0000;
    end else begin
      ram_en_q   <= ram_en_d;
      dec_addr_q <= dec_addr_d;
    end
  end

  // ************************************************************
  // cpu side outputs, registered
  // ************************************************************
  // no external cycle single
  // no external cycle in mode 00 either; region is still reported
  // the unsupported 00 code decodes like expanded rom in the map; gate it here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_region_q <= 6'b00_0000;
      ext_cycle_q  <= 1'b0;
    end else begin
      cpu_region_q <= cpu_valid ? cpu_region_w : 6'b00_0000;
      ext_cycle_q  <= cpu_valid && (cpu_region_w == MSD_EXT) &&
                      (mode_live != 2'b11) && (mode_live != 2'b00);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign cpu_region = cpu_region_q;
  assign ext_cycle  = ext_cycle_q;
endmodule

// ===== dv/msd_asserts.sv
// concurrent checks on the ports of msd_top, attached by bind
// assumes the apb master holds each request until pready
`timescale 1ns/1ps
module msd_asserts
  import msd_pkg::*;
(
  // ****************************************
  // watched ports
  // ****************************************
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        upper_mode_pin,
  input wire logic        lower_mode_pin,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_valid,
  input wire logic [5:0]  cpu_region,
  input wire logic        ext_cycle
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle of a read of the word holding the mode byte
  sequence s_mode_setup;
    psel && !penable && !pwrite && paddr[17:2] == 16'hffc5;
  endsequence
  sequence s_mode_done;
    s_mode_setup ##2 pready;
  endsequence
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
    else $error("error read without zero data");
  a_mode_fixed: assert property (s_mode_done |-> prdata[7:2] == 6'b111001)
    else $error("mode reserved bits wrong");
  a_mode_pins: assert property (s_mode_done |-> prdata[1:0] ==
    {$past(upper_mode_pin, 2), $past(lower_mode_pin, 2)})
    else $error("mode bits differ from pins");
  a_reg_field: assert property (cpu_valid && cpu_addr >= 16'hff88 |=> cpu_region == MSD_REG)
    else $error("register field not decoded");
  a_region_idle: assert property (!cpu_valid |=> cpu_region == 6'h00)
    else $error("region set without valid");
  a_ext_match: assert property (ext_cycle |-> cpu_region == MSD_EXT)
    else $error("external cycle outside external region");
endmodule

bind msd_top msd_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .upper_mode_pin(upper_mode_pin),
  .lower_mode_pin(lower_mode_pin), .cpu_addr(cpu_addr), .cpu_valid(cpu_valid),
  .cpu_region(cpu_region), .ext_cycle(ext_cycle));

// ===== dv/msd_cpu_model.sv
// cpu side model: puts one address per cycle on the decoder inputs
// assumes requests from the bench change right after rising edges
`timescale 1ns/1ps
module msd_cpu_model (
  // clock and request
  input  wire logic        pclk,
  input  wire logic [15:0] req_addr,
  input  wire logic        req_valid,
  // cpu address bus
  output logic      [15:0] cpu_addr,
  output logic             cpu_valid
);
  // idle bus shows the inverted request address so a stale address is never decoded by luck
  always_ff @(posedge pclk) begin
    cpu_addr  <= req_valid ? req_addr : ~req_addr;
    cpu_valid <= req_valid;
  end
endmodule

// ===== dv/msd_top_tb.sv
// self-checking bench for msd_top, 48k rom / 2k ram variant
// assumes the cpu model and the bound checker are compiled beside it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module msd_top_tb;
  import msd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        upper_mode_pin, lower_mode_pin, req_valid, cpu_valid, ext_cycle;
  logic [15:0] req_addr, cpu_addr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  cpu_region;
  int          miscompares, num_checks, cycles;
  msd_top #(.VARIANT(MSD_V48K)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upper_mode_pin(upper_mode_pin),
    .lower_mode_pin(lower_mode_pin), .cpu_addr(cpu_addr), .cpu_valid(cpu_valid),
    .cpu_region(cpu_region), .ext_cycle(ext_cycle));
  msd_cpu_model cpu_u (.pclk(pclk), .req_addr(req_addr), .req_valid(req_valid),
    .cpu_addr(cpu_addr), .cpu_valid(cpu_valid));
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // apb transfer; waits for pready, a dead slave is caught by the bench timeout
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd_mode(input logic [1:0] m);
    @(posedge pclk);
    upper_mode_pin <= m[1]; lower_mode_pin <= m[0];
    apb(0, 18'h3_ff14, 32'h0000_0000);
    `CHK("mode byte", {6'b111001, m}, rd[7:0])
  endtask
  task automatic dec(input logic [15:0] a, input msd_region_t e);
    @(posedge pclk);
    req_addr <= a; req_valid <= 1;
    @(posedge pclk);
    @(posedge pclk);
    #1;
    `CHK("region", e, cpu_region)
    `CHK("ext cycle", e == MSD_EXT, ext_cycle)
  endtask
  task automatic t_mode();
    for (int m = 1; m < 4; m++) begin
      rd_mode(m[1:0]);
      apb(1, 18'h3_ff14, 32'h0000_00fc); // write tries to flip mode byte
      rd_mode(m[1:0]);
      `CHK("upper half", 16'h0000, rd[31:16])
    end
    apb(0, 18'h0_1000, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(0, 18'h3_ff10, 32'h0000_0000);
    `CHK("ctrl reset", 32'h0000_0009, rd)
    apb(1, 18'h3_ff10, 32'h0000_0000);
    apb(0, 18'h3_ff10, 32'h0000_0000);
    `CHK("ctrl cleared", 32'h0000_0008, rd)
    apb(1, 18'h3_ff10, 32'h0000_0001);
    apb(1, 18'h3_fc00, 32'h0000_ff88);
    apb(0, 18'h3_fc00, 32'h0000_0000);
    `CHK("probe addr", 32'h0000_ff88, rd)
    apb(0, 18'h3_fc10, 32'h0000_0000);
    `CHK("probe region", 32'h0000_0008, rd)
    apb(0, 18'h3_fc20, 32'h0000_0000);
    `CHK("variant", 32'h0000_0000, rd)
    $display("test done: mode register");
  endtask
  task automatic t_decode(input logic [1:0] m);
    rd_mode(m);
    dec(16'h0048, m == 1 ? MSD_EXT : MSD_ROM);
    dec(16'hbfff, m == 1 ? MSD_EXT : MSD_ROM);
    dec(16'hc000, m == 3 ? MSD_RSV : MSD_EXT);
    dec(16'hf780, MSD_RAM);
    dec(16'hff7f, MSD_RAM);
    dec(16'hff80, m == 3 ? MSD_RSV : MSD_EXT);
    dec(16'hff88, MSD_REG);
    dec(16'hffff, MSD_REG);
    dec(16'h0047, MSD_VEC);
    apb(1, 18'h3_ff10, 32'h0000_0000);
    dec(16'hf780, m == 3 ? MSD_RAM : MSD_EXT);
    apb(1, 18'h3_ff10, 32'h0000_0001);
    $display("test done: decode mode %0d", m);
  endtask
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    upper_mode_pin = 1; lower_mode_pin = 1; req_addr = 0; req_valid = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    t_mode();
    for (int m = 1; m < 4; m++) t_decode(m[1:0]);
    @(posedge pclk);
    req_valid <= 0;
    repeat (3) @(posedge pclk);
    final_report();
  end
endmodule
